// ---- hdl/ppu_pkg.sv ----
// constants shared by the pulse pattern unit, its controller and their link
// Function
// - pin drives output data when direction and enable set
// - selected trigger copies enabled buffer bits to output
// - enable set, direction clear: input, output data read-only
// - controller refills buffer before next trigger
// - invert bit clear drives complement of output data
// - capture-configured channel A triggers by capture
// - other peripheral owns pin, transfer still happens
// - change pin setup only while no trigger occurs
// - non-overlap: compare A copies all enabled bits
// - non-overlap: compare B copies only zero bits
// - timer makes compare B precede compare A
// - buffer untouched between compare B and A
// - next pattern written before following compare B
// - pattern reload from compare A handler or engine
// - pulse pins need direction and enable both set
// - invert bits reset to one, direct output
// - non-overlap bits reset to zero, normal mode
// - halt bit resets set, blocks register access
package ppu_pkg;
  // ---------------------------------------------------------------
  // device geometry
  // ---------------------------------------------------------------
  localparam int unsigned PPU_PINS   = 16;
  localparam int unsigned PPU_GROUPS = 4;
  localparam int unsigned PPU_GW     = 4;
  localparam int unsigned PPU_CHANS  = 4;
  localparam int unsigned PPU_AW     = 3;
  // ---------------------------------------------------------------
  // device register indices on the link
  // ---------------------------------------------------------------
  localparam logic [2:0] PPU_REG_NDE   = 3'h0; // next_data_enable (high byte: next_data_enable_high)
  localparam logic [2:0] PPU_REG_NDB   = 3'h1; // next_data_buffer
  localparam logic [2:0] PPU_REG_POD   = 3'h2; // pulse_out_data
  localparam logic [2:0] PPU_REG_TSEL  = 3'h3; // trigger_select_reg, two bits per group
  localparam logic [2:0] PPU_REG_MODE  = 3'h4; // output_mode_reg: [7:4] invert, [3:0] nonoverlap
  localparam logic [2:0] PPU_REG_DIR   = 3'h5; // [15:8] port_one_direction, [7:0] port_two_direction
  localparam logic [2:0] PPU_REG_HALT  = 3'h6; // bit 0 module_halt_bit
  localparam logic [2:0] PPU_REG_PINS  = 3'h7; // synchronised pin levels, read only
  localparam logic [7:0] PPU_MODE_RST  = 8'hF0;
  localparam int unsigned PPU_INV_LSB  = 4;
  localparam logic       PPU_HALT_RST  = 1'h1;
  // ---------------------------------------------------------------
  // controller registers on AHB-Lite, byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] PPU_AHB_CMD    = 8'h00; // [15:0] data, [18:16] index, [19] write
  localparam logic [7:0] PPU_AHB_STATUS = 8'h04; // [0] busy, [1] late, [2] margin open
  localparam logic [7:0] PPU_AHB_CTRL   = 8'h08; // [0] margin guard enable
  localparam logic [7:0] PPU_AHB_RDATA  = 8'h0C; // [15:0] last link read data
  localparam int unsigned PPU_CMD_IDX_LSB = 16;
  localparam int unsigned PPU_CMD_WR_BIT  = 19;
  localparam int unsigned PPU_ST_LATE_BIT = 1;
  localparam logic [1:0] PPU_HTRANS_NONSEQ = 2'h2;
endpackage : ppu_pkg

// ---- hdl/ppu_link_if.sv ----
// link between the pulse pattern unit and its controller
`timescale 1ns/10ps
`default_nettype none
interface ppu_link_if;
  import ppu_pkg::*;
  logic                  req;       // one-cycle register request
  logic                  wr;        // request is a write
  logic [PPU_AW-1:0]     addr;      // register index
  logic [PPU_PINS-1:0]   wdata;
  logic                  ack;       // one-cycle answer
  logic [PPU_PINS-1:0]   rdata;
  logic [PPU_CHANS-1:0]  cmp_a;     // compare match A pulses per channel
  logic [PPU_CHANS-1:0]  cmp_b;     // compare match B pulses per channel
  logic [PPU_CHANS-1:0]  cap_a;     // input capture A pulses per channel
  logic [PPU_CHANS-1:0]  a_capture; // channel A register set for capture

  modport dev  (input req, wr, addr, wdata, cmp_a, cmp_b, cap_a, a_capture, output ack, rdata);
  modport ctrl (output req, wr, addr, wdata, cmp_a, cmp_b, cap_a, a_capture, input ack, rdata);
endinterface : ppu_link_if
`default_nettype wire

// ---- hdl/ppu_sync.sv ----
// two-flop synchroniser for pin levels
`timescale 1ns/10ps
`default_nettype none
module ppu_sync #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      meta   <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule : ppu_sync
`default_nettype wire

// ---- hdl/ppu_device.sv ----
// pulse pattern unit: pattern registers, trigger transfer and pin drive
`timescale 1ns/10ps
`default_nettype none
module ppu_device
  import ppu_pkg::*;
(
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst,
  ppu_link_if.dev                  link,
  input  wire logic [PPU_PINS-1:0] i_pin_in,
  input  wire logic [PPU_PINS-1:0] i_periph_oe,
  output logic      [PPU_PINS-1:0] o_pin_out,
  output logic      [PPU_PINS-1:0] o_pin_oe_n
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [PPU_PINS-1:0] next_data_enable;
  logic [PPU_PINS-1:0] next_data_buffer;
  logic [PPU_PINS-1:0] pulse_out_data;
  logic [PPU_PINS-1:0] direction;
  logic [7:0]          trigger_select_reg;
  logic [7:0]          output_mode_reg;
  logic                module_halt_bit;
  logic [PPU_PINS-1:0] pin_sync;
  logic                access;
  logic                wr_en;
  logic [PPU_PINS-1:0] xfer_mask;
  logic [PPU_PINS-1:0] inv_mask;
  logic [PPU_PINS-1:0] next_pulse_out_data;
  logic [PPU_PINS-1:0] read_mux;

  ppu_sync #(.WIDTH(PPU_PINS)) u_pin_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_async   (i_pin_in),
    .o_sync    (pin_sync)
  );

  // ---------------------------------------------------------------
  // register access
  // ---------------------------------------------------------------
  // halted unit answers but ignores all but its halt register
  assign access = link.req && (!module_halt_bit || link.addr == PPU_REG_HALT);
  assign wr_en  = access && link.wr;

  // plain configuration registers
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      next_data_enable   <= '0;
      next_data_buffer   <= '0;
      direction          <= '0;
      trigger_select_reg <= '0;
      output_mode_reg    <= PPU_MODE_RST;
      module_halt_bit    <= PPU_HALT_RST;
    end
    else if (wr_en)
    begin
      if (link.addr == PPU_REG_NDE)
        next_data_enable <= link.wdata;
      else if (link.addr == PPU_REG_NDB)
        next_data_buffer <= link.wdata;
      else if (link.addr == PPU_REG_TSEL)
        trigger_select_reg <= link.wdata[7:0];
      else if (link.addr == PPU_REG_MODE)
        output_mode_reg <= link.wdata[7:0];
      else if (link.addr == PPU_REG_DIR)
        direction <= link.wdata;
      else if (link.addr == PPU_REG_HALT)
        module_halt_bit <= link.wdata[0];
    end
  end

  // ---------------------------------------------------------------
  // trigger selection and transfer masks
  // ---------------------------------------------------------------
  // each group looks at the channel its two trigger_select_reg bits pick; triggers come from clocked logic, no sync needed
  always_comb
  begin
    logic [1:0] ch;
    logic       trig_a;
    logic       trig_b;
    logic [PPU_GW-1:0] en;
    logic [PPU_GW-1:0] nd;
    ch       = '0;
    trig_a   = 1'b0;
    trig_b   = 1'b0;
    en       = '0;
    nd       = '0;
    xfer_mask = '0;
    inv_mask  = '0;
    for (int g = 0; g < PPU_GROUPS; g++)
    begin
      ch     = trigger_select_reg[2*g +: 2];
      trig_a = link.a_capture[ch] ? link.cap_a[ch] : link.cmp_a[ch];
      trig_b = link.cmp_b[ch];
      en     = next_data_enable[PPU_GW*g +: PPU_GW];
      nd     = next_data_buffer[PPU_GW*g +: PPU_GW];
      if (!module_halt_bit && trig_a)
        xfer_mask[PPU_GW*g +: PPU_GW] = en;
      else if (!module_halt_bit && trig_b && output_mode_reg[g])
        xfer_mask[PPU_GW*g +: PPU_GW] = en & ~nd;
      // group 3 and 2 sit in the upper byte
      inv_mask[PPU_GW*g +: PPU_GW] = {PPU_GW{~output_mode_reg[PPU_INV_LSB+g]}};
    end
  end

  // software writes only bits not owned by the pattern; trigger wins over write
  always_comb
  begin
    next_pulse_out_data = pulse_out_data;
    if (wr_en && link.addr == PPU_REG_POD)
      next_pulse_out_data = (pulse_out_data & next_data_enable)
                          | (link.wdata & ~next_data_enable);
    next_pulse_out_data = (next_pulse_out_data & ~xfer_mask)
                        | (next_data_buffer & xfer_mask);
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      pulse_out_data <= '0;
    else
      pulse_out_data <= next_pulse_out_data;
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  // inversion applies to pulse pins only; general outputs show data as is
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_pin_out  <= '0;
      o_pin_oe_n <= '1;
    end
    else
    begin
      o_pin_out  <= pulse_out_data ^ (inv_mask & next_data_enable);
      o_pin_oe_n <= ~(direction & ~i_periph_oe);
    end
  end

  // ---------------------------------------------------------------
  // read answer
  // ---------------------------------------------------------------
  always_comb
  begin
    read_mux = '0;
    if (link.addr == PPU_REG_NDE)
      read_mux = next_data_enable;
    else if (link.addr == PPU_REG_NDB)
      read_mux = next_data_buffer;
    else if (link.addr == PPU_REG_POD)
      read_mux = pulse_out_data;
    else if (link.addr == PPU_REG_TSEL)
      read_mux = {8'h00, trigger_select_reg};
    else if (link.addr == PPU_REG_MODE)
      read_mux = {8'h00, output_mode_reg};
    else if (link.addr == PPU_REG_DIR)
      read_mux = direction;
    else if (link.addr == PPU_REG_HALT)
      read_mux = {15'h0000, module_halt_bit};
    else
      read_mux = pin_sync;
  end

  // every request gets an answer so the controller never hangs
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      link.ack   <= 1'b0;
      link.rdata <= '0;
    end
    else
    begin
      link.ack   <= link.req;
      link.rdata <= (access && !link.wr) ? read_mux : '0;
    end
  end
endmodule : ppu_device
`default_nettype wire

// ---- hdl/ppu_ctrl.sv ----
// controller: AHB-Lite registers, link master and timer trigger relay
`timescale 1ns/10ps
`default_nettype none
module ppu_ctrl
  import ppu_pkg::*;
(
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_hsel,
  input  wire logic [31:0]          i_haddr,
  input  wire logic [1:0]           i_htrans,
  input  wire logic                 i_hwrite,
  input  wire logic [2:0]           i_hsize,
  input  wire logic [31:0]          i_hwdata,
  input  wire logic                 i_hready,
  output logic                      o_hreadyout,
  output logic [31:0]               o_hrdata,
  output logic                      o_hresp,
  input  wire logic [PPU_CHANS-1:0] i_cmp_a,
  input  wire logic [PPU_CHANS-1:0] i_cmp_b,
  input  wire logic [PPU_CHANS-1:0] i_cap_a,
  input  wire logic [PPU_CHANS-1:0] i_a_capture,
  ppu_link_if.ctrl                  link
);
  typedef enum logic [2:0] {
    PPU_ST_IDLE = 3'b001,
    PPU_ST_HOLD = 3'b010,
    PPU_ST_BUSY = 3'b100
  } ppu_state_e;

  ppu_state_e          state;
  logic                dphase_wr;
  logic [7:0]          dphase_addr;
  logic                cmd_pend;
  logic                cmd_wr;
  logic [PPU_AW-1:0]   cmd_idx;
  logic [PPU_PINS-1:0] cmd_data;
  logic [PPU_PINS-1:0] last_rdata;
  logic                guard_en;
  logic                late;
  logic [PPU_CHANS-1:0] margin;
  logic                cmd_take;
  logic                blocked;
  logic                st_clr;

  // ---------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      dphase_wr   <= 1'b0;
      dphase_addr <= '0;
      o_hrdata    <= '0;
    end
    else if (i_hready)
    begin
      dphase_wr   <= i_hsel && i_htrans == PPU_HTRANS_NONSEQ && i_hwrite;
      dphase_addr <= i_haddr[7:0];
      o_hrdata    <= '0;
      if (i_haddr[7:0] == PPU_AHB_STATUS)
        o_hrdata <= {29'h0, |margin, late, state != PPU_ST_IDLE || cmd_pend};
      else if (i_haddr[7:0] == PPU_AHB_CTRL)
        o_hrdata <= {31'h0, guard_en};
      else if (i_haddr[7:0] == PPU_AHB_RDATA)
        o_hrdata <= {16'h0000, last_rdata};
    end
  end

  // slave never stalls and never errors
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
    else
    begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
  end

  assign cmd_take = dphase_wr && dphase_addr == PPU_AHB_CMD && !cmd_pend && state == PPU_ST_IDLE;
  assign st_clr   = dphase_wr && dphase_addr == PPU_AHB_STATUS && i_hwdata[PPU_ST_LATE_BIT];

  // command latch; a command written while busy is dropped
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      cmd_pend <= 1'b0;
      cmd_wr   <= 1'b0;
      cmd_idx  <= '0;
      cmd_data <= '0;
      guard_en <= 1'b0;
    end
    else
    begin
      if (cmd_take)
      begin
        cmd_pend <= 1'b1;
        cmd_wr   <= i_hwdata[PPU_CMD_WR_BIT];
        cmd_idx  <= i_hwdata[PPU_CMD_IDX_LSB +: PPU_AW];
        cmd_data <= i_hwdata[PPU_PINS-1:0];
      end
      else if (state == PPU_ST_BUSY && link.ack)
        cmd_pend <= 1'b0;
      if (dphase_wr && dphase_addr == PPU_AHB_CTRL)
        guard_en <= i_hwdata[0];
    end
  end

  // ---------------------------------------------------------------
  // margin tracking between compare B and compare A
  // ---------------------------------------------------------------
  // B opens the margin, A closes it; B ahead of A is assumed of the timer
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      margin <= '0;
    else
      margin <= (margin | i_cmp_b) & ~i_cmp_a;
  end

  // buffer writes wait out an open margin
  assign blocked = guard_en && |margin && cmd_wr && cmd_idx == PPU_REG_NDB;

  // late flag: pattern still pending at compare B; set wins over clear
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      late <= 1'b0;
    else if (cmd_pend && cmd_wr && cmd_idx == PPU_REG_NDB && |i_cmp_b)
      late <= 1'b1;
    else if (st_clr)
      late <= 1'b0;
  end

  // ---------------------------------------------------------------
  // link master
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      state      <= PPU_ST_IDLE;
      link.req   <= 1'b0;
      link.wr    <= 1'b0;
      link.addr  <= '0;
      link.wdata <= '0;
      last_rdata <= '0;
    end
    else
    begin
      link.req <= 1'b0;
      case (state)
        PPU_ST_IDLE:
        begin
          if (cmd_pend)
            state <= PPU_ST_HOLD;
        end
        PPU_ST_HOLD:
        begin
          if (!blocked)
          begin
            link.req   <= 1'b1;
            link.wr    <= cmd_wr;
            link.addr  <= cmd_idx;
            link.wdata <= cmd_data;
            state      <= PPU_ST_BUSY;
          end
        end
        PPU_ST_BUSY:
        begin
          if (link.ack)
          begin
            if (!cmd_wr)
              last_rdata <= link.rdata;
            state <= PPU_ST_IDLE;
          end
        end
        default:
          state <= PPU_ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // timer trigger relay, one register stage
  // ---------------------------------------------------------------
  // setup changes are software's job to place where no trigger falls
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      link.cmp_a     <= '0;
      link.cmp_b     <= '0;
      link.cap_a     <= '0;
      link.a_capture <= '0;
    end
    else
    begin
      link.cmp_a     <= i_cmp_a;
      link.cmp_b     <= i_cmp_b;
      link.cap_a     <= i_cap_a;
      link.a_capture <= i_a_capture;
    end
  end
endmodule : ppu_ctrl
`default_nettype wire

// ---- tb/ppu_link_assertions.sv ----
// concurrent checks on the link between the pulse pattern unit and its controller
`timescale 1ns/10ps
`default_nettype none
module ppu_link_assertions
  import ppu_pkg::*;
(
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst,
  input  wire logic                req,
  input  wire logic                wr,
  input  wire logic [PPU_AW-1:0]   addr,
  input  wire logic [PPU_PINS-1:0] wdata,
  input  wire logic                ack,
  input  wire logic [PPU_PINS-1:0] rdata
);
  // ---------------------------------------------------------------
  // shadow state
  // ---------------------------------------------------------------
  logic       halted;
  logic [7:0] mode_sh;
  logic [7:0] tsel_sh;
  // halt writes always land, others only while running
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      halted  <= PPU_HALT_RST;
      mode_sh <= PPU_MODE_RST;
      tsel_sh <= 8'h00;
    end
    else if (req && wr)
    begin
      if (addr == PPU_REG_HALT)
        halted <= wdata[0];
      if (!halted && addr == PPU_REG_MODE)
        mode_sh <= wdata[7:0];
      if (!halted && addr == PPU_REG_TSEL)
        tsel_sh <= wdata[7:0];
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  ack_after_req_a:
    assert property (req |=> ack) else $error("no answer one cycle after a request");
  ack_has_req_a:
    assert property (ack |-> $past(req)) else $error("answer without a request");
  ack_single_a:
    assert property (ack |=> !ack) else $error("answer held past one cycle");
  rdata_quiet_a:
    assert property (!ack |-> rdata == '0) else $error("read data outside an answer");
  req_spacing_a:
    assert property (req |-> !ack ##1 !req) else $error("requests too close together");
  halt_read_a:
    assert property (ack && !$past(wr) && $past(halted) && $past(addr) != PPU_REG_HALT |-> rdata == '0)
      else $error("halted unit answered a read");
  mode_read_a:
    assert property (ack && !$past(wr) && !$past(halted) && $past(addr) == PPU_REG_MODE
      |-> rdata[7:0] == $past(mode_sh)) else $error("mode read differs from reset or written value");
  tsel_read_a:
    assert property (ack && !$past(wr) && !$past(halted) && $past(addr) == PPU_REG_TSEL
      |-> rdata[7:0] == $past(tsel_sh)) else $error("trigger select read differs from written value");
endmodule : ppu_link_assertions
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the pulse pattern unit and its controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("ERROR %s exp %h seen %h", nm, e, g); end end
module tb_top import ppu_pkg::*;;
  logic        i_sys_clk = 1'b0;
  logic        i_rst     = 1'b1;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = '0;
  logic [1:0]  htrans    = '0;
  logic        hwrite    = 1'b0;
  logic [31:0] hwdata    = '0;
  logic [2:0]  hsize     = 3'h2;
  logic        hready;
  logic        hresp;
  logic        hr_n;
  logic [31:0] hrdata;
  logic [31:0] rd_n;
  logic [3:0]  cmp_a     = '0;
  logic [3:0]  cmp_b     = '0;
  logic [3:0]  cap_a     = '0;
  logic [3:0]  a_cap     = '0;
  logic [15:0] pin_in    = 16'h5A3C;
  logic [15:0] poe       = '0;
  logic [15:0] pin_out;
  logic [15:0] oe_n;
  int          n_fail    = 0;
  int          tests_run = 0;
  // ---------------------------------------------------------------
  // the two ends, their link and the checker
  // ---------------------------------------------------------------
  ppu_link_if link ();
  ppu_ctrl ppu_ctrl_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
    .o_hrdata(hrdata), .o_hresp(hresp), .i_cmp_a(cmp_a), .i_cmp_b(cmp_b), .i_cap_a(cap_a),
    .i_a_capture(a_cap), .link(link));
  ppu_device ppu_device_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .link(link), .i_pin_in(pin_in),
    .i_periph_oe(poe), .o_pin_out(pin_out), .o_pin_oe_n(oe_n));
  ppu_link_assertions ppu_link_assertions_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .req(link.req),
    .wr(link.wr), .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
  // clock, and bus answer sampled mid-cycle so the edge never races it
  initial forever #50 i_sys_clk = ~i_sys_clk;
  always @(negedge i_sys_clk)
  begin
    hr_n <= hready;
    rd_n <= hrdata;
  end
  // ---------------------------------------------------------------
  // bus and trigger tasks
  // ---------------------------------------------------------------
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= PPU_HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge i_sys_clk); while (hr_n !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_sys_clk); while (hr_n !== 1'b1);
    q = rd_n;
  endtask : ahb
  // one link access: command, poll busy, fetch the answer
  task automatic lnk(input logic w, input logic [2:0] i, input logic [15:0] d, output logic [15:0] q);
    logic [31:0] t;
    ahb(1'b1, PPU_AHB_CMD, {12'h0, w, i, d}, t);
    do ahb(1'b0, PPU_AHB_STATUS, 32'h0, t); while (t[0] !== 1'b0);
    ahb(1'b0, PPU_AHB_RDATA, 32'h0, t);
    q = t[15:0];
  endtask : lnk
  task automatic wr(input logic [2:0] i, input logic [15:0] d);
    logic [15:0] q;
    lnk(1'b1, i, d, q);
  endtask : wr
  task automatic ck_reg(input string nm, input logic [2:0] i, input logic [15:0] e);
    logic [15:0] q;
    lnk(1'b0, i, 16'h0, q);
    `CHK(nm, e, q)
  endtask : ck_reg
  task automatic trig(input logic [3:0] a, input logic [3:0] b, input logic [3:0] c);
    cmp_a <= a;
    cmp_b <= b;
    cap_a <= c;
    @(posedge i_sys_clk);
    cmp_a <= 4'h0;
    cmp_b <= 4'h0;
    cap_a <= 4'h0;
    repeat (4) @(posedge i_sys_clk);
  endtask : trig
  task automatic ck_pins(input logic [15:0] e, input logic [15:0] eoe);
    @(negedge i_sys_clk);
    `CHK("pin_out", e, pin_out)
    `CHK("pin_oe_n", eoe, oe_n)
    @(posedge i_sys_clk);
  endtask : ck_pins
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] t;
    ck_pins(16'h0000, 16'hFFFF);
    wr(PPU_REG_NDE, 16'hFFFF);
    ck_reg("halted read", PPU_REG_MODE, 16'h0000);
    wr(PPU_REG_HALT, 16'h0000);
    ck_reg("nde blocked", PPU_REG_NDE, 16'h0000);
    ck_reg("mode reset", PPU_REG_MODE, {8'h00, PPU_MODE_RST});
    ck_reg("pin levels", PPU_REG_PINS, 16'h5A3C);
    `CHK("hresp", 1'b0, hresp)
    ahb(1'b0, 8'h10, 32'h0, t);
    `CHK("unmapped", 32'h0, t)
    $display("test reset done");
  endtask : t_reset
  task automatic t_normal();
    logic [7:0] pat [4] = '{8'hC0, 8'h40, 8'h60, 8'h20};
    wr(PPU_REG_DIR, 16'hFFF0);
    wr(PPU_REG_NDE, 16'hF8FF);
    wr(PPU_REG_TSEL, 16'h0050);
    wr(PPU_REG_NDB, 16'h80A5);
    trig(4'h1, 4'h0, 4'h0);
    ck_reg("pod low", PPU_REG_POD, 16'h00A5);
    ck_pins(16'h00A5, 16'h000F);
    trig(4'h2, 4'h0, 4'h0);
    ck_pins(16'h80A5, 16'h000F);
    foreach (pat[k])
    begin
      wr(PPU_REG_NDB, {pat[k], 8'hA5});
      trig(4'h2, 4'h0, 4'h0);
      ck_pins({pat[k], 8'hA5}, 16'h000F);
    end
    wr(PPU_REG_POD, 16'h0700);
    ck_pins(16'h27A5, 16'h000F);
    $display("test normal done");
  endtask : t_normal
  task automatic t_nov();
    wr(PPU_REG_MODE, 16'h0030);
    ck_pins(16'hDFA5, 16'h000F);
    wr(PPU_REG_MODE, 16'h00FC);
    wr(PPU_REG_NDE, 16'hFFFF);
    wr(PPU_REG_NDB, 16'h95A5);
    trig(4'h2, 4'h0, 4'h0);
    ck_pins(16'h95A5, 16'h000F);
    wr(PPU_REG_NDB, 16'h65A5);
    trig(4'h0, 4'h2, 4'h0);
    ck_pins(16'h05A5, 16'h000F);
    poe <= 16'h0100;
    trig(4'h2, 4'h0, 4'h0);
    ck_pins(16'h65A5, 16'h010F);
    poe <= 16'h0000;
    $display("test nonoverlap done");
  endtask : t_nov
  task automatic t_capture();
    a_cap <= 4'h1;
    wr(PPU_REG_NDB, 16'h655A);
    trig(4'h1, 4'h0, 4'h0);
    ck_pins(16'h65A5, 16'h000F);
    trig(4'h0, 4'h0, 4'h1);
    ck_pins(16'h655A, 16'h000F);
    wr(PPU_REG_NDB, 16'h6533);
    wr(PPU_REG_HALT, 16'h0001);
    trig(4'h0, 4'h0, 4'h1);
    ck_pins(16'h655A, 16'h000F);
    wr(PPU_REG_HALT, 16'h0000);
    trig(4'h0, 4'h0, 4'h1);
    ck_pins(16'h6533, 16'h000F);
    $display("test capture done");
  endtask : t_capture
  // margin guard holds a buffer write from B to A; a B while it waits marks it late
  task automatic t_guard();
    logic [31:0] t;
    ahb(1'b1, PPU_AHB_CTRL, 32'h1, t);
    trig(4'h0, 4'h2, 4'h0);
    ahb(1'b1, PPU_AHB_CMD, {12'h0, 1'b1, PPU_REG_NDB, 16'h9933}, t);
    ahb(1'b0, PPU_AHB_STATUS, 32'h0, t);
    `CHK("write held in margin", 32'h5, t)
    trig(4'h0, 4'h2, 4'h0);
    trig(4'h2, 4'h0, 4'h0);
    ahb(1'b0, PPU_AHB_STATUS, 32'h0, t);
    `CHK("late after second B", 32'h2, t)
    ahb(1'b1, PPU_AHB_STATUS, 32'h2, t);
    ahb(1'b0, PPU_AHB_STATUS, 32'h0, t);
    `CHK("late cleared", 32'h0, t)
    ck_pins(16'h6533, 16'h000F);
    ck_reg("buffer after margin", PPU_REG_NDB, 16'h9933);
    ahb(1'b1, PPU_AHB_CTRL, 32'h0, t);
    $display("test guard done");
  endtask : t_guard
  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  // watchdog: the whole sequence needs a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge i_sys_clk);
    n_fail++;
    $display("ERROR watchdog exp done seen timeout");
    complete_run();
  end
  initial
  begin
    repeat (10) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    t_reset();
    t_normal();
    t_nov();
    t_capture();
    t_guard();
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
